/* File: rtl/psc_sram_ctrl.v */
// Purpose: Pin-level control of a synchronous pipelined burst SRAM, array included.
// Assumes: Host drives all synchronous pins from logic on the same 50 MHz clock.
// Notes: Output enable and burst strap are pins from outside and are synchronised.
//
// Overview of operation
// - Address captured on qualified rising edges with advance low.
// - Each lane select writes its own byte.
// - Lane selects write only in a burst loaded with write strobe.
// - Write strobe sampled only on qualified edges.
// - Advance high steps the internal burst counter.
// - Advance low loads a fresh start address.
// - Edges ignored while clock qualifier is high.
// - Selected only when first, third low, second high.
// - Output enable low lets data pins drive.
// - Pins float on write data, emerge, deselect.
// - Read data comes from preceding read address.
// - Qualifier high stretches cycle, state unchanged.
// - Strap high interleaved, low linear burst order.
`timescale 1ns/1ns
`include "psc_regs.vh"

module psc_sram_ctrl (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Clock qualifier, low to recognise an edge
	input wire clock_qualifier_n,
	// Address
	input wire addr_bit_zero,
	input wire addr_bit_one,
	input wire [`PSC_UPPER_W-1:0] addr_upper,
	// Access control
	input wire write_n,
	input wire [`PSC_LANES-1:0] byte_lane_write_n,
	input wire advance_or_load,
	// Chip selects
	input wire chip_select_first_n,
	input wire chip_select_second,
	input wire chip_select_third_n,
	// Asynchronous output enable and burst order strap
	input wire output_enable_n,
	input wire burst_mode_strap,
	// Data pins, split into input, output and enable
	input wire [`PSC_DATA_W-1:0] data_in,
	input wire [`PSC_LANES-1:0] data_check_bits_in,
	output reg [`PSC_DATA_W-1:0] data_out,
	output reg [`PSC_LANES-1:0] data_check_bits_out,
	output reg data_oe_n
);

	// ****************************************
	// Access states, one-hot
	// ****************************************
	localparam [2:0] ST_DESEL = 3'h1;
	localparam [2:0] ST_READ = 3'h2;
	localparam [2:0] ST_WRITE = 3'h4;

	// ****************************************
	// Helper functions
	// ****************************************

	// Next low address bits of a burst; interleave uses xor, linear adds
	function [1:0] burst_lo;
		input [1:0] start;
		input [1:0] count;
		input interleave;
		begin
			if (interleave) begin
				burst_lo = start ^ count;
			end else begin
				burst_lo = start + count;
			end
		end
	endfunction

	// Pack data and check bits into lanes of nine bits
	function [`PSC_WORD_W-1:0] pack_word;
		input [`PSC_DATA_W-1:0] data;
		input [`PSC_LANES-1:0] check;
		integer k;
		begin
			pack_word = {`PSC_WORD_W{1'b0}};
			for (k = 0; k < `PSC_LANES; k = k + 1) begin
				pack_word[k*`PSC_LANE_W +: `PSC_LANE_DATA_W] =
					data[k*`PSC_LANE_DATA_W +: `PSC_LANE_DATA_W];
				pack_word[k*`PSC_LANE_W + `PSC_LANE_CHECK_BIT] = check[k];
			end
		end
	endfunction

	// Merge new lanes over old ones where the lane select is low
	function [`PSC_WORD_W-1:0] merge_lanes;
		input [`PSC_WORD_W-1:0] old_word;
		input [`PSC_WORD_W-1:0] new_word;
		input [`PSC_LANES-1:0] lane_n;
		integer k;
		begin
			merge_lanes = old_word;
			for (k = 0; k < `PSC_LANES; k = k + 1) begin
				if (!lane_n[k]) begin
					merge_lanes[k*`PSC_LANE_W +: `PSC_LANE_W] =
						new_word[k*`PSC_LANE_W +: `PSC_LANE_W];
				end
			end
		end
	endfunction

	// ****************************************
	// Storage array
	// ****************************************
	reg [`PSC_WORD_W-1:0] mem_q [0:`PSC_DEPTH-1];

	// ****************************************
	// Pipeline registers
	// ****************************************
	reg [2:0] st1_ff;
	reg [`PSC_ADDR_W-1:0] addr1_ff;
	reg [1:0] base_lo_ff;
	reg [1:0] cnt_ff;
	reg [`PSC_LANES-1:0] lanes1_ff;
	reg [2:0] st2_ff;
	reg [`PSC_ADDR_W-1:0] addr2_ff;
	reg [`PSC_LANES-1:0] lanes2_ff;

	reg [2:0] nxt_st1;
	reg [`PSC_ADDR_W-1:0] nxt_addr1;
	reg [1:0] nxt_base_lo;
	reg [1:0] nxt_cnt;
	reg [`PSC_LANES-1:0] nxt_lanes1;
	reg [`PSC_WORD_W-1:0] nxt_rd_word;
	reg nxt_data_oe_n;

	wire qualified;
	wire selected;
	wire oe_level_n;
	wire interleave;
	wire [`PSC_WORD_W-1:0] wr_word;
	wire [`PSC_WORD_W-1:0] stored_rd;

	// Every edge counts only with the qualifier low; otherwise all state holds
	assign qualified = ~clock_qualifier_n;

	// Selection needs exactly this combination of the three chip selects
	assign selected = ~chip_select_first_n & chip_select_second & ~chip_select_third_n;

	// Incoming write data packed into lanes
	assign wr_word = pack_word(data_in, data_check_bits_in);

	// Stored word for the address held in the first stage
	assign stored_rd = mem_q[addr1_ff];

	// ****************************************
	// Pin synchronisers
	// ****************************************

	// Output enable is asynchronous, so it reaches the drivers five edges late
	psc_sync3 #(
		.RST_VAL(`PSC_OE_N_RST)
	) u_oe_sync (
		.clock(clock),
		.rst_n(rst_n),
		.enable(qualified),
		.pin_in(output_enable_n),
		.level_out(oe_level_n)
	);

	// Strap is sampled on every qualified edge; it is expected to stay still in use
	psc_sync3 #(
		.RST_VAL(`PSC_MODE_RST)
	) u_mode_sync (
		.clock(clock),
		.rst_n(rst_n),
		.enable(qualified),
		.pin_in(burst_mode_strap),
		.level_out(interleave)
	);

	// ****************************************
	// Address and command stage
	// ****************************************

	// Load or advance decides the next access and its address
	always @* begin
		nxt_st1 = st1_ff;
		nxt_addr1 = addr1_ff;
		nxt_base_lo = base_lo_ff;
		nxt_cnt = cnt_ff;
		nxt_lanes1 = `PSC_LANES_OFF;
		if (!advance_or_load) begin
			// Fresh start address, low bits become the burst base
			nxt_addr1 = {addr_upper, addr_bit_one, addr_bit_zero};
			nxt_base_lo = {addr_bit_one, addr_bit_zero};
			nxt_cnt = `PSC_CNT_RST;
			if (!selected) begin
				nxt_st1 = ST_DESEL;
			end else if (!write_n) begin
				// Strobe is looked at only here, on a qualified load edge
				nxt_st1 = ST_WRITE;
				nxt_lanes1 = byte_lane_write_n;
			end else begin
				nxt_st1 = ST_READ;
			end
		end else begin
			// Advance keeps the access type; a deselect stays deselected
			nxt_cnt = cnt_ff + 2'h1;
			nxt_addr1[`PSC_BURST_HI:`PSC_BURST_LO] =
				burst_lo(base_lo_ff, cnt_ff + 2'h1, interleave);
			case (st1_ff)
				ST_WRITE: begin
					nxt_lanes1 = byte_lane_write_n;
				end
				ST_READ: begin
					nxt_lanes1 = `PSC_LANES_OFF;
				end
				ST_DESEL: begin
					nxt_lanes1 = `PSC_LANES_OFF;
				end
				default: begin
					nxt_st1 = ST_DESEL;
				end
			endcase
		end
	end

	// First stage registers, held whenever the qualifier is high
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st1_ff <= ST_DESEL;
			addr1_ff <= {`PSC_ADDR_W{1'b0}};
			base_lo_ff <= `PSC_CNT_RST;
			cnt_ff <= `PSC_CNT_RST;
			lanes1_ff <= `PSC_LANES_OFF;
		end else if (qualified) begin
			st1_ff <= nxt_st1;
			addr1_ff <= nxt_addr1;
			base_lo_ff <= nxt_base_lo;
			cnt_ff <= nxt_cnt;
			lanes1_ff <= nxt_lanes1;
		end
	end

	// ****************************************
	// Write data stage
	// ****************************************

	// Second stage holds a write until its data arrives one edge later
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st2_ff <= ST_DESEL;
			addr2_ff <= {`PSC_ADDR_W{1'b0}};
			lanes2_ff <= `PSC_LANES_OFF;
		end else if (qualified) begin
			st2_ff <= st1_ff;
			addr2_ff <= addr1_ff;
			lanes2_ff <= lanes1_ff;
		end
	end

	// Commit write data taken from the pins, only on selected lanes
	always @(posedge clock) begin
		if (qualified && st2_ff == ST_WRITE) begin
			mem_q[addr2_ff] <= merge_lanes(mem_q[addr2_ff], wr_word, lanes2_ff);
		end
	end

	// ****************************************
	// Read and output stage
	// ****************************************

	// A write landing on the same word this edge is forwarded, not missed
	always @* begin
		nxt_rd_word = stored_rd;
		if (st2_ff == ST_WRITE && addr2_ff == addr1_ff) begin
			nxt_rd_word = merge_lanes(stored_rd, wr_word, lanes2_ff);
		end
	end

	// Drive only for a read with enable low; write data, emerge, deselect float
	always @* begin
		nxt_data_oe_n = 1'b1;
		case (st1_ff)
			ST_READ: begin
				nxt_data_oe_n = oe_level_n;
			end
			ST_WRITE: begin
				nxt_data_oe_n = 1'b1;
			end
			ST_DESEL: begin
				nxt_data_oe_n = 1'b1;
			end
			default: begin
				nxt_data_oe_n = 1'b1;
			end
		endcase
	end

	// Output register; the first cycle after a deselect still drives if a read preceded it
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= {`PSC_DATA_W{1'b0}};
			data_check_bits_out <= {`PSC_LANES{1'b0}};
			data_oe_n <= 1'b1;
		end else if (qualified) begin
			data_oe_n <= nxt_data_oe_n;
			if (st1_ff == ST_READ) begin
				// Data from the address taken on the preceding read edge
				data_out[7:0] <= nxt_rd_word[7:0];
				data_out[15:8] <= nxt_rd_word[16:9];
				data_out[23:16] <= nxt_rd_word[25:18];
				data_out[31:24] <= nxt_rd_word[34:27];
				data_check_bits_out[0] <= nxt_rd_word[8];
				data_check_bits_out[1] <= nxt_rd_word[17];
				data_check_bits_out[2] <= nxt_rd_word[26];
				data_check_bits_out[3] <= nxt_rd_word[35];
			end
		end
	end

endmodule

/* File: rtl/psc_regs.vh */
// Purpose: Shared constants for the pipelined SRAM pin-control block.
// Assumes: Included by bare name from every design file that needs it.
// Notes: No processes or assignments here, definitions only.
`ifndef PSC_REGS_VH
`define PSC_REGS_VH

// ****************************************
// Array geometry
// ****************************************
`define PSC_ADDR_W 20
`define PSC_UPPER_W 18
`define PSC_DEPTH (1 << `PSC_ADDR_W)
`define PSC_DATA_W 32
`define PSC_LANES 4
`define PSC_LANE_W 9
`define PSC_WORD_W 36

// ****************************************
// Field positions inside a stored word
// ****************************************
`define PSC_LANE_DATA_W 8
`define PSC_LANE_CHECK_BIT 8
`define PSC_BURST_LO 0
`define PSC_BURST_HI 1

// ****************************************
// Reset values
// ****************************************
`define PSC_OE_N_RST 1'h1
`define PSC_MODE_RST 1'h1
`define PSC_LANES_OFF 4'hF
`define PSC_CNT_RST 2'h0

// ****************************************
// Timing counts, in qualified clock edges
// ****************************************
`define PSC_READ_LAT 2
`define PSC_WRITE_LAT 2
`define PSC_SYNC_STAGES 3

`endif

/* File: rtl/psc_sync3.v */
// Purpose: Three-stage synchroniser with an agreement filter for a pin input.
// Assumes: One clock; enable low freezes every stage.
// Notes: The output changes only when the second and third stages agree.
`timescale 1ns/1ns
`include "psc_regs.vh"

module psc_sync3 #(
	parameter [0:0] RST_VAL = 1'h1
) (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Freeze control
	input wire enable,
	// Pin side
	input wire pin_in,
	// Filtered level
	output reg level_out
);

	// ****************************************
	// Capture stages
	// ****************************************
	reg stage1_ff;
	reg stage2_ff;
	reg stage3_ff;

	// First stage is read only by the second, to keep metastability contained
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage1_ff <= RST_VAL;
			stage2_ff <= RST_VAL;
			stage3_ff <= RST_VAL;
			level_out <= RST_VAL;
		end else if (enable) begin
			stage1_ff <= pin_in;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
			// A change counts only once two settled stages agree
			if (stage2_ff == stage3_ff) begin
				level_out <= stage3_ff;
			end
		end
	end

endmodule

/* File: bench/psc_sram_ctrl_properties.sv */
// Purpose: Port timing checks for the SRAM pin-control block.
// Assumes: One clock, rst_n asynchronous and active low.
// Notes: Output enable is trusted only after six qualified edges.
`timescale 1ns/1ns
`include "psc_regs.vh"
module psc_sram_ctrl_properties (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Host controls
	input wire clock_qualifier_n,
	input wire write_n,
	input wire advance_or_load,
	input wire chip_select_first_n,
	input wire chip_select_second,
	input wire chip_select_third_n,
	input wire output_enable_n,
	// Data outputs
	input wire [`PSC_DATA_W-1:0] data_out,
	input wire [`PSC_LANES-1:0] data_check_bits_out,
	input wire data_oe_n
);
	// ****
	// Decodes
	// ****
	wire sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
	wire load = !clock_qualifier_n && !advance_or_load;
	wire oe_on = !output_enable_n && !clock_qualifier_n;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_hold_oe;
		clock_qualifier_n |=> data_oe_n == $past(data_oe_n);
	endproperty
	a_hold_oe: assert property (p_hold_oe) else $error("enable moved on masked edge");
	property p_hold_data;
		$changed({data_out, data_check_bits_out}) |-> $past(!clock_qualifier_n);
	endproperty
	a_hold_data: assert property (p_hold_data) else $error("data moved on masked edge");
	property p_desel_float;
		load && !sel ##1 !clock_qualifier_n |=> data_oe_n;
	endproperty
	a_desel_float: assert property (p_desel_float) else $error("driven while deselected");
	property p_write_float;
		load && sel && !write_n ##1 !clock_qualifier_n |=> data_oe_n;
	endproperty
	a_write_float: assert property (p_write_float) else $error("driven in write data");
	property p_desel_adv;
		load && !sel ##1 (!clock_qualifier_n && advance_or_load) ##1 !clock_qualifier_n |=> data_oe_n;
	endproperty
	a_desel_adv: assert property (p_desel_adv) else $error("advance left deselect");
	property p_oe_off;
		(output_enable_n && !clock_qualifier_n)[*6] |=> data_oe_n;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("driven with enable high");
	property p_read_drive;
		oe_on[*6] ##0 (load && sel && write_n) ##1 oe_on |=> !data_oe_n;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read data not driven");
	property p_reset_float;
		// One edge of reset must pass first: the outputs are unknown before it
		@(posedge clock) disable iff (1'b0) !rst_n ##1 !rst_n |-> data_oe_n && data_out == '0;
	endproperty
	a_reset_float: assert property (p_reset_float) else $error("driven in reset");
endmodule

/* File: bench/psc_host_model.sv */
// Purpose: Host controller model driving the SRAM pins.
// Assumes: One command per call, each on a qualified edge.
// Notes: Write data follows its load by two qualified edges.
`timescale 1ns/1ns
`include "psc_regs.vh"
module psc_host_model (
	// Clock
	input wire clock,
	// Synchronous controls, cs is {first_n, second, third_n}
	output reg clock_qualifier_n = 1'h1,
	output reg [`PSC_ADDR_W-1:0] addr = 20'h00000,
	output reg write_n = 1'h1,
	output reg [`PSC_LANES-1:0] byte_lane_write_n = 4'hF,
	output reg advance_or_load = 1'h0,
	output reg [2:0] cs = 3'h3,
	// Write data
	output reg [`PSC_WORD_W-1:0] wdata = 36'h0
);
	reg [`PSC_WORD_W-1:0] cmd_w = 36'h0;
	reg [`PSC_WORD_W-1:0] pipe_w = 36'h0;
	// ****
	// Pins
	// ****
	// Data moves only on qualified edges, so a stall keeps it valid
	always @(posedge clock) begin
		if (!clock_qualifier_n) begin
			pipe_w <= cmd_w;
			wdata <= pipe_w;
		end
	end
	// Command held until the next call
	task issue(input adv, input wn, input [2:0] c, input [3:0] ln, input [19:0] a,
		input [35:0] w);
		begin
			@(posedge clock);
			clock_qualifier_n <= 1'h0;
			advance_or_load <= adv;
			write_n <= wn;
			cs <= c;
			byte_lane_write_n <= ln;
			addr <= a;
			cmd_w <= w;
		end
	endtask
	// Mask n edges
	task stall(input integer n);
		begin
			@(posedge clock);
			clock_qualifier_n <= 1'h1;
			repeat (n - 1) @(posedge clock);
		end
	endtask
endmodule

/* File: bench/psc_sram_ctrl_tb.sv */
// Purpose: Self-checking bench for the SRAM pin-control block.
// Assumes: Strap starts high (interleaved); a mid-run reset switches it to linear.
// Notes: All traffic stays in one 16-word window.
`timescale 1ns/1ns
`include "psc_regs.vh"
module psc_sram_ctrl_tb;
	localparam [19:0] base_addr = 20'h5A3C0;
	reg clock = 1'h0;
	reg rst_n = 1'h0;
	reg output_enable_n = 1'h1;
	reg drive = 1'h0;
	reg strap = 1'h1;
	reg last_qn = 1'h1;
	reg wr, sel;
	reg [3:0] cur;
	reg [1:0] st, cnt;
	reg [31:0] seed = 32'h8DDB;
	reg [35:0] ref_mem [0:15];
	reg [35:0] exp_q [$];
	wire qn, wn, adv, oe_n;
	wire [19:0] addr;
	wire [3:0] ln, chk;
	wire [2:0] cs;
	wire [35:0] wdata;
	wire [31:0] dout;
	integer fails = 0;
	integer checks = 0;
	integer j;
	psc_host_model psc_host_model_inst (.clock(clock), .clock_qualifier_n(qn), .addr(addr),
		.write_n(wn), .byte_lane_write_n(ln), .advance_or_load(adv), .cs(cs), .wdata(wdata));
	psc_sram_ctrl psc_sram_ctrl_inst (.clock(clock), .rst_n(rst_n), .clock_qualifier_n(qn),
		.addr_bit_zero(addr[0]), .addr_bit_one(addr[1]), .addr_upper(addr[19:2]),
		.write_n(wn), .byte_lane_write_n(ln), .advance_or_load(adv),
		.chip_select_first_n(cs[2]), .chip_select_second(cs[1]), .chip_select_third_n(cs[0]),
		.output_enable_n(output_enable_n), .burst_mode_strap(strap), .data_in(wdata[31:0]),
		.data_check_bits_in(wdata[35:32]), .data_out(dout), .data_check_bits_out(chk),
		.data_oe_n(oe_n));
	// ****
	// Helpers
	// ****
	initial forever #10 clock = ~clock;
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task check(input [35:0] seen, input [35:0] want);
		begin
			checks = checks + 1;
			if (seen !== want) begin
				fails = fails + 1;
				$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
			end
		end
	endtask
	task wrap_up;
		begin
			if (fails == 0 && checks > 0) $display("bench passed");
			else $display("bench failed");
			$finish;
		end
	endtask
	// Kind 0 read, 1 write, 2 advance; expectations noted at issue
	task op(input [1:0] k, input [2:0] c, input [3:0] lanes, input [3:0] a);
		reg [35:0] w;
		integer i;
		begin
			seed = lfsr(seed);
			w = {seed[7:4], lfsr(seed)};
			if (k != 2'h2) begin
				cur = a;
				st = a[1:0];
				cnt = 2'h0;
				wr = (k == 2'h1);
				sel = (c == 3'h2);
			end else begin
				cnt = cnt + 2'h1;
				cur[1:0] = strap ? st ^ cnt : st + cnt;
			end
			for (i = 0; i < 4; i = i + 1) begin
				if (sel && wr && !lanes[i]) begin
					ref_mem[cur][8*i +: 8] = w[8*i +: 8];
					ref_mem[cur][32+i] = w[32+i];
				end
			end
			if (sel && !wr && drive) exp_q.push_back(ref_mem[cur]);
			psc_host_model_inst.issue(k == 2'h2, (k == 2'h2) ? seed[9] : !wr, c, lanes,
				(k == 2'h2) ? seed[19:0] : base_addr | a, w);
		end
	endtask
	// Each result lands after one qualified edge, so stalls never count twice
	always @(posedge clock) begin
		if (rst_n && !last_qn && oe_n === 1'h0)
			check({chk, dout}, (exp_q.size() != 0) ? exp_q.pop_front() : 36'hX);
		last_qn <= qn;
	end
	// Far beyond the fewer than two hundred cycles the sequence needs
	initial begin
		#(20 * 3000);
		fails = fails + 1;
		wrap_up;
	end
	// ****
	// Sequence
	// ****
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'h1;
		for (j = 0; j < 10; j = j + 1) op(2'h0, j[2:0], 4'hF, 4'h0);
		output_enable_n <= 1'h0;
		for (j = 0; j < 8; j = j + 1) op(2'h0, 3'h7, 4'hF, 4'h0);
		drive = 1'h1;
		for (j = 0; j < 16; j = j + 1) op(2'h1, 3'h2, 4'h0, j[3:0]);
		op(2'h1, 3'h2, 4'hA, 4'h5);
		op(2'h0, 3'h2, 4'h0, 4'h5);
		op(2'h0, 3'h2, 4'hF, 4'h9);
		op(2'h2, 3'h2, 4'hF, 4'h0);
		psc_host_model_inst.stall(3);
		op(2'h2, 3'h2, 4'hF, 4'h0);
		op(2'h2, 3'h2, 4'hF, 4'h0);
		op(2'h1, 3'h2, 4'h0, 4'h6);
		psc_host_model_inst.stall(2);
		op(2'h2, 3'h2, 4'h3, 4'h0);
		op(2'h2, 3'h2, 4'hC, 4'h0);
		for (j = 4; j < 8; j = j + 1) op(2'h0, 3'h2, 4'hF, j[3:0]);
		op(2'h0, 3'h7, 4'hF, 4'h0);
		op(2'h2, 3'h7, 4'hF, 4'h0);
		op(2'h0, 3'h2, 4'hF, 4'h1);
		for (j = 0; j < 40; j = j + 1) begin
			seed = lfsr(seed);
			if (seed[13]) psc_host_model_inst.stall(1);
			op(seed[1] ? 2'h2 : {1'h0, seed[0]}, (seed[4:2] == 3'h7) ? 3'h5 : 3'h2,
				seed[8:5], seed[12:9]);
		end
		// Enable high: once the synchroniser settles, reads must float and nothing is compared
		output_enable_n <= 1'h1;
		drive = 1'h0;
		for (j = 0; j < 12; j = j + 1) op(2'h0, (j < 6) ? 3'h0 : 3'h2, 4'hF, j[3:0]);
		// Mid-run reset changes the burst order while idle; the array keeps its words
		rst_n <= 1'h0;
		strap <= 1'h0;
		output_enable_n <= 1'h0;
		repeat (2) @(posedge clock);
		rst_n <= 1'h1;
		// Both synchronisers need a few qualified edges before the new levels count
		for (j = 0; j < 6; j = j + 1) op(2'h0, 3'h0, 4'hF, 4'h0);
		drive = 1'h1;
		// Start 5 tells the orders apart: linear 5,6,7,4 against interleaved 5,4,7,6
		for (j = 0; j < 4; j = j + 1) op((j == 0) ? 2'h0 : 2'h2, 3'h2, 4'hF, 4'h5);
		for (j = 0; j < 4; j = j + 1) op(2'h0, 3'h0, 4'hF, 4'h0);
		repeat (4) @(posedge clock);
		check({4'h0, exp_q.size()}, 36'h0);
		wrap_up;
	end
endmodule
bind psc_sram_ctrl psc_sram_ctrl_properties psc_sram_ctrl_properties_inst (.clock(clock),
	.rst_n(rst_n), .clock_qualifier_n(clock_qualifier_n), .write_n(write_n),
	.advance_or_load(advance_or_load), .chip_select_first_n(chip_select_first_n),
	.chip_select_second(chip_select_second), .chip_select_third_n(chip_select_third_n),
	.output_enable_n(output_enable_n), .data_out(data_out),
	.data_check_bits_out(data_check_bits_out), .data_oe_n(data_oe_n));
